/* File: flash_host_ctrl.sv */
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int ADDR_W = 23,
	parameter int CNT_W  = 8
) (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              byte_mode,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire cmd_t              cmd_code,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [15:0]       cmd_data,
	input  wire logic [CNT_W-1:0]  cmd_count,
	input  wire logic              word_valid,
	output logic                   word_ready,
	input  wire logic [ADDR_W-1:0] word_addr,
	input  wire logic [15:0]       word_data,
	output logic                   rsp_valid,
	output logic                   rsp_error,
	output logic      [15:0]       rsp_data,
	output logic                   rsp_protected,
	output mode_t                  mode,
	output logic      [ADDR_W-1:0] flash_addr,
	output logic      [15:0]       flash_dq_out,
	output logic                   flash_dq_oe_n,
	input  wire logic [15:0]       flash_dq_in,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n,
	output logic                   flash_byte_n
);

	// ************
	// Elaboration checks
	// ************
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 12 and 32");
	end
	if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
		$error("CNT_W must lie between 1 and 16");
	end

	// ************
	// Step table
	// ************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
		logic              rd;
		logic              last;
	} step_t;

	function automatic logic [ADDR_W-1:0] ext(logic [11:0] a);
		ext = {{(ADDR_W-12){1'b0}}, a};
	endfunction

	function automatic step_t mk(logic [ADDR_W-1:0] a, logic [15:0] d,
		logic rd, logic last);
		step_t r;
		r.addr = a;
		r.data = d;
		r.rd   = rd;
		r.last = last;
		mk = r;
	endfunction

	// Commands that open with the two unlock cycles
	function automatic logic has_unlock(cmd_t c);
		case (c)
			CMD_PROGRAM, CMD_BUF_LOAD, CMD_BUF_ABORT, CMD_CHIP_ERASE,
			CMD_SECT_ERASE, CMD_DPD_ENTER, CMD_LREG_ENTER,
			CMD_PPB_ENTER, CMD_FRZ_ENTER: has_unlock = 1'b1;
			default: has_unlock = 1'b0;
		endcase
	endfunction

	// Address, data and kind of bus cycle number s of command c
	function automatic step_t step_info(cmd_t c, logic [2:0] s,
		logic bm, logic [ADDR_W-1:0] a, logic [15:0] d,
		logic [15:0] n);
		logic [ADDR_W-1:0] u1, u2, qa;
		u1 = ext(bm ? A_U1_B : A_U1_W);
		u2 = ext(bm ? A_U2_B : A_U2_W);
		qa = ext(bm ? A_QRY_B : A_QRY_W);
		step_info = mk(a, C_ZERO, 1'b1, 1'b1);
		if (has_unlock(c) && s == 3'd0) begin
			step_info = mk(u1, C_UNLK1, 1'b0, 1'b0);
		end else if (has_unlock(c) && s == 3'd1) begin
			step_info = mk(u2, C_UNLK2, 1'b0, 1'b0);
		end else begin
			case (c)
				CMD_PROGRAM: step_info = (s == 3'd2) ?
					mk(u1, C_PROG, 1'b0, 1'b0) :
					mk(a, d, 1'b0, 1'b1);
				CMD_BUF_LOAD: step_info = (s == 3'd2) ?
					mk(a, C_BUF, 1'b0, 1'b0) :
					mk(a, n, 1'b0, 1'b1);
				CMD_BUF_ABORT:
					step_info = mk(u1, C_RESET, 1'b0, 1'b1);
				CMD_CHIP_ERASE, CMD_SECT_ERASE: case (s)
					3'd2: step_info = mk(u1, C_ERASE, 1'b0, 1'b0);
					3'd3: step_info = mk(u1, C_UNLK1, 1'b0, 1'b0);
					3'd4: step_info = mk(u2, C_UNLK2, 1'b0, 1'b0);
					default: step_info = (c == CMD_CHIP_ERASE) ?
						mk(u1, C_CHIP, 1'b0, 1'b1) :
						mk(a, C_SECT, 1'b0, 1'b1);
				endcase
				CMD_DPD_ENTER:
					step_info = mk(a, C_DPD, 1'b0, 1'b1);
				CMD_LREG_ENTER:
					step_info = mk(u1, C_LREG, 1'b0, 1'b1);
				CMD_PPB_ENTER:
					step_info = mk(u1, C_PPB, 1'b0, 1'b1);
				CMD_FRZ_ENTER:
					step_info = mk(u1, C_FRZ, 1'b0, 1'b1);
				CMD_BUF_CONFIRM:
					step_info = mk(a, C_CONF, 1'b0, 1'b1);
				CMD_QUERY:
					step_info = mk(qa, C_QUERY, 1'b0, 1'b1);
				CMD_RESET:
					step_info = mk(a, C_RESET, 1'b0, 1'b1);
				CMD_SUSPEND:
					step_info = mk(a, C_SUSP, 1'b0, 1'b1);
				CMD_RESUME:
					step_info = mk(a, C_RESUME, 1'b0, 1'b1);
				CMD_DPD_EXIT:
					step_info = mk(a, C_DPDX, 1'b0, 1'b1);
				CMD_LREG_PROG: step_info = (s == 3'd0) ?
					mk(a, C_PROG, 1'b0, 1'b0) :
					mk(a, d, 1'b0, 1'b1);
				CMD_SET_EXIT: step_info = (s == 3'd0) ?
					mk(a, C_EXIT1, 1'b0, 1'b0) :
					mk(a, C_ZERO, 1'b0, 1'b1);
				CMD_PPB_PROG: step_info = (s == 3'd0) ?
					mk(a, C_PROG, 1'b0, 1'b0) :
					mk(a, C_ZERO, 1'b0, 1'b1);
				CMD_PPB_ERASE: step_info = (s == 3'd0) ?
					mk(a, C_ERASE, 1'b0, 1'b0) :
					mk(ext(A_ZERO), C_SECT, 1'b0, 1'b1);
				CMD_FRZ_SET: step_info = (s == 3'd0) ?
					mk(a, C_PROG, 1'b0, 1'b0) :
					mk(a, C_ZERO, 1'b0, 1'b1);
				default: step_info = mk(a, C_ZERO, 1'b1, 1'b1);
			endcase
		end
	endfunction

	// ************
	// Mode tracking
	// ************
	// Commands that the device would treat as a broken order are
	// refused here, so no partial sequence ever reaches the pins
	function automatic logic legal(cmd_t c, mode_t m);
		case (m)
			MD_DPD: legal = (c == CMD_DPD_EXIT);
			MD_QUERY: legal = (c == CMD_RESET ||
				c == CMD_ARRAY_READ);
			MD_BUF: legal = (c == CMD_BUF_CONFIRM ||
				c == CMD_BUF_ABORT);
			MD_SUSP: legal = (c == CMD_RESUME || c == CMD_RESET ||
				c == CMD_ARRAY_READ || c == CMD_QUERY);
			MD_LREG: legal = (c == CMD_LREG_PROG ||
				c == CMD_LREG_READ || c == CMD_SET_EXIT);
			MD_PPB: legal = (c == CMD_PPB_PROG || c == CMD_PPB_ERASE ||
				c == CMD_PPB_READ || c == CMD_SET_EXIT);
			MD_FRZ: legal = (c == CMD_FRZ_SET ||
				c == CMD_FRZ_READ || c == CMD_SET_EXIT);
			default: legal = !(c == CMD_BUF_CONFIRM ||
				c == CMD_DPD_EXIT || c == CMD_LREG_PROG ||
				c == CMD_LREG_READ || c == CMD_SET_EXIT ||
				c == CMD_PPB_PROG || c == CMD_PPB_ERASE ||
				c == CMD_PPB_READ || c == CMD_FRZ_SET ||
				c == CMD_FRZ_READ);
		endcase
	endfunction

	// Device mode once command c has completed
	function automatic mode_t next_mode(cmd_t c, mode_t m);
		case (c)
			CMD_BUF_LOAD:    next_mode = MD_BUF;
			CMD_BUF_CONFIRM: next_mode = MD_ARRAY;
			CMD_BUF_ABORT:   next_mode = MD_ARRAY;
			CMD_QUERY:       next_mode = MD_QUERY;
			CMD_RESET:       next_mode = MD_ARRAY;
			CMD_SUSPEND:     next_mode = MD_SUSP;
			CMD_RESUME:      next_mode = MD_ARRAY;
			CMD_DPD_ENTER:   next_mode = MD_DPD;
			CMD_DPD_EXIT:    next_mode = MD_ARRAY;
			CMD_LREG_ENTER:  next_mode = MD_LREG;
			CMD_PPB_ENTER:   next_mode = MD_PPB;
			CMD_FRZ_ENTER:   next_mode = MD_FRZ;
			CMD_SET_EXIT:    next_mode = MD_ARRAY;
			default:         next_mode = m;
		endcase
	endfunction

	// ************
	// State
	// ************
	main_st_t          st_q, st_d;
	cmd_t              cmd_q, cmd_d;
	mode_t             mode_q, mode_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [15:0]       data_q, data_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [2:0]        step_q, step_d;
	logic              rsp_valid_d, rsp_error_d, prot_d;
	logic [15:0]       rsp_data_d;
	logic              byte_n_d;
	step_t             info;
	logic              cy_start, cy_rd, cy_done;
	logic [ADDR_W-1:0] cy_addr;
	logic [15:0]       cy_wdata, cy_rdata, dq_sync;

	assign mode = mode_q;
	assign info = step_info(cmd_q, step_q, byte_mode, addr_q, data_q,
		{{(16-CNT_W){1'b0}}, cnt_q});

	// Handshakes are combinational from the sequencer state
	assign cmd_ready  = (st_q == M_IDLE);
	assign word_ready = (st_q == M_WORD);

	// Bus cycle source: command step or a buffer word pair
	always_comb begin
		cy_start = (st_q == M_ISSUE) || (st_q == M_WORD && word_valid);
		cy_rd    = (st_q == M_WORD) ? 1'b0 : info.rd;
		cy_addr  = (st_q == M_WORD) ? word_addr : info.addr;
		cy_wdata = (st_q == M_WORD) ? word_data : info.data;
	end

	// ************
	// Sequencer
	// ************
	// Steps one command through its cycles; a buffer load then
	// takes count+1 pairs from the word port before finishing
	always_comb begin
		st_d        = st_q;
		cmd_d       = cmd_q;
		mode_d      = mode_q;
		addr_d      = addr_q;
		data_d      = data_q;
		cnt_d       = cnt_q;
		step_d      = step_q;
		rsp_valid_d = 1'b0;
		rsp_error_d = 1'b0;
		rsp_data_d  = rsp_data;
		prot_d      = rsp_protected;
		byte_n_d    = !byte_mode;
		case (st_q)
			M_IDLE: if (cmd_valid) begin
				if (!legal(cmd_code, mode_q)) begin
					rsp_valid_d = 1'b1;
					rsp_error_d = 1'b1;
				end else begin
					st_d   = M_ISSUE;
					cmd_d  = cmd_code;
					addr_d = cmd_addr;
					data_d = cmd_data;
					cnt_d  = cmd_count;
					step_d = 3'd0;
				end
			end
			M_ISSUE: st_d = M_WAIT;
			M_WAIT: if (cy_done) begin
				if (info.rd) begin
					rsp_data_d = cy_rdata;
					// Only 00 means protected or frozen
					prot_d = (cy_rdata[7:0] == ST_LOCKED);
				end
				if (!info.last) begin
					step_d = step_q + 3'd1;
					st_d   = M_ISSUE;
				end else if (cmd_q == CMD_BUF_LOAD) begin
					st_d = M_WORD;
				end else begin
					st_d        = M_IDLE;
					mode_d      = next_mode(cmd_q, mode_q);
					rsp_valid_d = 1'b1;
				end
			end
			M_WORD: if (word_valid) st_d = M_WWAIT;
			M_WWAIT: if (cy_done) begin
				if (cnt_q == '0) begin
					st_d        = M_IDLE;
					mode_d      = next_mode(cmd_q, mode_q);
					rsp_valid_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
					st_d  = M_WORD;
				end
			end
			default: st_d = M_IDLE;
		endcase
	end

	// Sequencer registers; the freeze lock state is not modelled,
	// only a reset of the device clears it, not a command
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q          <= M_IDLE;
			cmd_q         <= CMD_ARRAY_READ;
			mode_q        <= MD_ARRAY;
			addr_q        <= '0;
			data_q        <= 16'h0000;
			cnt_q         <= '0;
			step_q        <= 3'd0;
			rsp_valid     <= 1'b0;
			rsp_error     <= 1'b0;
			rsp_data      <= 16'h0000;
			rsp_protected <= 1'b0;
			flash_byte_n  <= 1'b1;
		end else begin
			st_q          <= st_d;
			cmd_q         <= cmd_d;
			mode_q        <= mode_d;
			addr_q        <= addr_d;
			data_q        <= data_d;
			cnt_q         <= cnt_d;
			step_q        <= step_d;
			rsp_valid     <= rsp_valid_d;
			rsp_error     <= rsp_error_d;
			rsp_data      <= rsp_data_d;
			rsp_protected <= prot_d;
			flash_byte_n  <= byte_n_d;
		end
	end

	// ************
	// Pin side
	// ************
	// Read data comes from an unclocked device: synchronise first
	bit_sync #(
		.W (16)
	) u_dq_sync (
		.clock  (clock),
		.resetn (resetn),
		.d      (flash_dq_in),
		.q      (dq_sync)
	);

	flash_cycle #(
		.ADDR_W (ADDR_W)
	) u_cycle (
		.clock     (clock),
		.resetn    (resetn),
		.start     (cy_start),
		.rd        (cy_rd),
		.addr      (cy_addr),
		.wdata     (cy_wdata),
		.dq_sync   (dq_sync),
		.done      (cy_done),
		.rdata_q   (cy_rdata),
		.addr_q    (flash_addr),
		.wdata_q   (flash_dq_out),
		.dq_oe_n_q (flash_dq_oe_n),
		.ce_n_q    (flash_ce_n),
		.we_n_q    (flash_we_n),
		.oe_n_q    (flash_oe_n)
	);

endmodule

/* File: flash_host_pkg.sv */
// ************
// ************
package flash_host_pkg;

	// ************
	// Timing
	// ************
	localparam int CLK_MHZ   = 250;
	localparam int T_SETUP_NS = 10;
	localparam int T_WE_NS    = 35;
	localparam int T_HOLD_NS  = 20;
	localparam int T_ACC_NS   = 70;
	localparam int SYNC_CYC   = 2;
	// Least times, rounded up to whole cycles
	localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_CYC    = (T_WE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC  = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] SETUP_LD = 5'(SETUP_CYC - 1);
	localparam logic [4:0] WE_LD    = 5'(WE_CYC - 1);
	localparam logic [4:0] HOLD_LD  = 5'(HOLD_CYC - 1);
	localparam logic [4:0] RD_LD    = 5'(ACC_CYC + SYNC_CYC - 1);

	// ************
	// Bus codes and addresses
	// ************
	localparam logic [15:0] C_UNLK1  = 16'h00AA;
	localparam logic [15:0] C_UNLK2  = 16'h0055;
	localparam logic [15:0] C_PROG   = 16'h00A0;
	localparam logic [15:0] C_BUF    = 16'h0025;
	localparam logic [15:0] C_CONF   = 16'h0029;
	localparam logic [15:0] C_RESET  = 16'h00F0;
	localparam logic [15:0] C_ERASE  = 16'h0080;
	localparam logic [15:0] C_CHIP   = 16'h0010;
	localparam logic [15:0] C_SECT   = 16'h0030;
	localparam logic [15:0] C_RESUME = 16'h0030;
	localparam logic [15:0] C_QUERY  = 16'h0098;
	localparam logic [15:0] C_SUSP   = 16'h00B0;
	localparam logic [15:0] C_DPD    = 16'h00B9;
	localparam logic [15:0] C_DPDX   = 16'h00AB;
	localparam logic [15:0] C_LREG   = 16'h0040;
	localparam logic [15:0] C_EXIT1  = 16'h0090;
	localparam logic [15:0] C_ZERO   = 16'h0000;
	localparam logic [15:0] C_PPB    = 16'h00C0;
	localparam logic [15:0] C_FRZ    = 16'h0050;
	localparam logic [11:0] A_U1_W   = 12'h555;
	localparam logic [11:0] A_U1_B   = 12'hAAA;
	localparam logic [11:0] A_U2_W   = 12'h2AA;
	localparam logic [11:0] A_U2_B   = 12'h555;
	localparam logic [11:0] A_QRY_W  = 12'h055;
	localparam logic [11:0] A_QRY_B  = 12'h0AA;
	localparam logic [11:0] A_ZERO   = 12'h000;
	localparam logic [7:0]  ST_LOCKED = 8'h00;

	// ************
	// Types
	// ************
	typedef enum logic [4:0] {
		CMD_PROGRAM, CMD_BUF_LOAD, CMD_BUF_CONFIRM, CMD_BUF_ABORT,
		CMD_CHIP_ERASE, CMD_SECT_ERASE, CMD_QUERY, CMD_RESET,
		CMD_SUSPEND, CMD_RESUME, CMD_DPD_ENTER, CMD_DPD_EXIT,
		CMD_LREG_ENTER, CMD_LREG_PROG, CMD_LREG_READ, CMD_SET_EXIT,
		CMD_PPB_ENTER, CMD_PPB_PROG, CMD_PPB_ERASE, CMD_PPB_READ,
		CMD_FRZ_ENTER, CMD_FRZ_SET, CMD_FRZ_READ, CMD_ARRAY_READ
	} cmd_t;
	typedef enum logic [2:0] {
		MD_ARRAY, MD_BUF, MD_QUERY, MD_SUSP,
		MD_DPD, MD_LREG, MD_PPB, MD_FRZ
	} mode_t;
	typedef enum logic [1:0] {
		CY_IDLE = 2'b00, CY_SETUP = 2'b01,
		CY_PULSE = 2'b11, CY_HOLD = 2'b10
	} cyc_st_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_ISSUE = 3'b001, M_WAIT = 3'b011,
		M_WORD = 3'b010, M_WWAIT = 3'b110
	} main_st_t;

endpackage

/* File: bit_sync.sv */
module bit_sync
	import flash_host_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// Two stages; only the second stage is read outside
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

/* File: flash_cycle.sv */
module flash_cycle
	import flash_host_pkg::*;
#(
	parameter int ADDR_W = 23
) (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              start,
	input  wire logic              rd,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [15:0]       wdata,
	input  wire logic [15:0]       dq_sync,
	output logic                   done,
	output logic      [15:0]       rdata_q,
	output logic      [ADDR_W-1:0] addr_q,
	output logic      [15:0]       wdata_q,
	output logic                   dq_oe_n_q,
	output logic                   ce_n_q,
	output logic                   we_n_q,
	output logic                   oe_n_q
);

	cyc_st_t           st_q, st_d;
	logic [4:0]        cnt_q, cnt_d;
	logic              rd_q, rd_d;
	logic [ADDR_W-1:0] addr_d;
	logic [15:0]       wdata_d, rdata_d;
	logic              dq_oe_n_d, ce_n_d, we_n_d, oe_n_d;

	// One bus cycle: setup, strobe, recovery; pins follow the state
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		rd_d    = rd_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		done    = 1'b0;
		if (cnt_q != 5'h00) cnt_d = cnt_q - 5'h01;
		case (st_q)
			CY_IDLE: if (start) begin
				st_d    = CY_SETUP;
				cnt_d   = SETUP_LD;
				rd_d    = rd;
				addr_d  = addr;
				wdata_d = wdata;
			end
			CY_SETUP: if (cnt_q == 5'h00) begin
				st_d  = CY_PULSE;
				cnt_d = rd_q ? RD_LD : WE_LD;
			end
			CY_PULSE: if (cnt_q == 5'h00) begin
				// Read strobe covers access time plus synchroniser lag
				if (rd_q) rdata_d = dq_sync;
				st_d  = CY_HOLD;
				cnt_d = HOLD_LD;
			end
			CY_HOLD: if (cnt_q == 5'h00) begin
				st_d = CY_IDLE;
				done = 1'b1;
			end
			default: st_d = CY_IDLE;
		endcase
		ce_n_d    = (st_d == CY_IDLE);
		we_n_d    = !(st_d == CY_PULSE && !rd_d);
		oe_n_d    = !(st_d == CY_PULSE && rd_d);
		dq_oe_n_d = rd_d || (st_d == CY_IDLE);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q      <= CY_IDLE;
			cnt_q     <= 5'h00;
			rd_q      <= 1'b0;
			addr_q    <= '0;
			wdata_q   <= 16'h0000;
			rdata_q   <= 16'h0000;
			dq_oe_n_q <= 1'b1;
			ce_n_q    <= 1'b1;
			we_n_q    <= 1'b1;
			oe_n_q    <= 1'b1;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			rd_q      <= rd_d;
			addr_q    <= addr_d;
			wdata_q   <= wdata_d;
			rdata_q   <= rdata_d;
			dq_oe_n_q <= dq_oe_n_d;
			ce_n_q    <= ce_n_d;
			we_n_q    <= we_n_d;
			oe_n_q    <= oe_n_d;
		end
	end

endmodule

/* File: flash_host_ctrl_monitor.sv */
module flash_host_ctrl_monitor #(
	parameter int ADDR_W = 23
) (
	input wire logic              clock,
	input wire logic              resetn,
	input wire logic              byte_mode,
	input wire logic              cmd_ready,
	input wire logic              rsp_valid,
	input wire logic              rsp_error,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [15:0]       flash_dq_out,
	input wire logic              flash_dq_oe_n,
	input wire logic              flash_ce_n,
	input wire logic              flash_we_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_byte_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ************
	// Write strobe shape
	// ************
	sequence s_we_low;
		(!flash_we_n)[*8];
	endsequence
	sequence s_we_end;
		s_we_low ##1 flash_we_n;
	endsequence

	// Nine cycles low in all, counted from the falling edge
	a_we_width: assert property ($fell(flash_we_n) |-> ##1 s_we_end)
		else $error("write strobe width wrong");
	a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n)
		else $error("write strobe outside select");
	a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
		else $error("read and write strobes together");
	a_read_float: assert property (!flash_oe_n |-> flash_dq_oe_n)
		else $error("data driven during read");
	a_addr_steady: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved in write");
	a_setup_gap: assert property ($fell(flash_we_n) |-> $past(flash_ce_n, 3) == 1'b0)
		else $error("select setup too short");
	a_hold_end: assert property ($rose(flash_we_n) |-> ##[0:8] flash_ce_n)
		else $error("select not released after write");
	a_error_pulse: assert property (rsp_error |-> rsp_valid)
		else $error("error without response");
	a_idle_quiet: assert property (cmd_ready |-> flash_we_n && flash_oe_n)
		else $error("strobe active while idle");
	a_byte_pin: assert property (flash_byte_n == !$past(byte_mode))
		else $error("byte pin does not follow mode");
endmodule

bind flash_host_ctrl flash_host_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (
	.clock(clock), .resetn(resetn), .byte_mode(byte_mode),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
	.flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
	.flash_byte_n(flash_byte_n)
);

/* File: flash_dev_model.sv */
module flash_dev_model
	import flash_host_pkg::*;
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [22:0] addr,
	input wire logic [15:0] dq_out,
	output logic     [15:0] dq_in,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic        byte_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [38:0] log[$];
	logic [38:0] h1, h2;
	logic [15:0] lreg, p1, idle, rd;
	logic [22:0] u1, u2;
	logic [2:0]  md;
	bit          frz;
	bit          ppb[logic [22:0]];

	// ************
	// Command decode
	// ************
	assign u1 = byte_n ? 23'h000555 : 23'h000AAA;
	assign u2 = byte_n ? 23'h0002AA : 23'h000555;
	initial begin
		idle = 16'hA5C3;
		lreg = 16'hFFFF;
	end
	// Freeze bit is volatile, protect bits are not
	always @(negedge resetn) begin
		md = 3'd0;
		frz = 1'b0;
		p1 = 16'hFFFF;
	end
	// Writes latch on the rising write strobe
	always @(posedge we_n) if (!ce_n) begin : cap
		logic [2:0] om;
		om = md;
		log.push_back({addr, dq_out});
		case (md)
		3'd0: if (dq_out == 16'h0098 && addr == (byte_n ? 23'h55 : 23'hAA))
				md = 3'd2;
			else if (h1 == {u1, 16'h00AA} && h2 == {u2, 16'h0055}) begin
				if (dq_out == 16'h00B9) md = 3'd4;
				else if (addr == u1 && dq_out == 16'h0040) md = 3'd5;
				else if (addr == u1 && dq_out == 16'h00C0) md = 3'd6;
				else if (addr == u1 && dq_out == 16'h0050) md = 3'd7;
			end
		3'd2: if (dq_out == 16'h00F0) md = 3'd0;
		3'd4: if (dq_out == 16'h00AB) md = 3'd0;
		3'd5: if (p1 == 16'h00A0) lreg = dq_out;
		3'd6: if (!frz && p1 == 16'h00A0 && dq_out == 16'h0000)
				ppb[addr] = 1'b1;
			else if (!frz && p1 == 16'h0080 && dq_out == 16'h0030 && addr == 0)
				ppb.delete();
		3'd7: if (p1 == 16'h00A0 && dq_out == 16'h0000) frz = 1'b1;
		default: ;
		endcase
		if (om >= 3'd5 && p1 == 16'h0090 && dq_out == 16'h0000)
			md = 3'd0;
		p1 = (om < 3'd5 || p1 != 16'hFFFF) ? 16'hFFFF : dq_out;
		h1 = h2;
		h2 = {addr, dq_out};
	end

	// ************
	// Read answers
	// ************
	// Status 00 is protected, 01 unprotected
	always @(negedge oe_n) begin
		case (md)
		3'd5: rd = lreg;
		3'd6: rd = ppb.exists(addr) ? 16'h0000 : 16'h0001;
		3'd7: rd = frz ? 16'h0000 : 16'h0001;
		default: rd = addr[15:0] ^ 16'h5A5A;
		endcase
	end
	// Released bus toggles so stale data never looks valid
	always @(posedge clock) idle <= ~idle;
	assign dq_in = oe_n ? idle : rd;
endmodule

/* File: flash_host_ctrl_tb.sv */
module flash_host_ctrl_tb
	import flash_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	bad_count++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
	logic        clock, resetn, byte_mode, cmd_valid, word_valid;
	logic        cmd_ready, word_ready, rsp_valid, rsp_error, rsp_protected;
	logic        dq_oe_n, ce_n, we_n, oe_n, byte_n, er_g;
	logic [22:0] cmd_addr, word_addr, f_addr, a;
	logic [15:0] cmd_data, word_data, rsp_data, dq_out, dq_in, d;
	logic [7:0]  cmd_count;
	logic [38:0] exq[$], wq[$];
	cmd_t        cmd_code;
	mode_t       mode;
	int          bad_count, check_count, cyc;

	flash_host_ctrl i_flash_host_ctrl (.clock(clock), .resetn(resetn),
		.byte_mode(byte_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_count(cmd_count), .word_valid(word_valid),
		.word_ready(word_ready), .word_addr(word_addr),
		.word_data(word_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
		.rsp_data(rsp_data), .rsp_protected(rsp_protected), .mode(mode),
		.flash_addr(f_addr), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
		.flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .flash_byte_n(byte_n));
	flash_dev_model i_flash_dev_model (.clock(clock), .resetn(resetn),
		.addr(f_addr), .dq_out(dq_out), .dq_in(dq_in), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .byte_n(byte_n));

	// ************
	// Expected bus writes
	// ************
	function automatic logic [22:0] u1();
		return byte_mode ? 23'h000AAA : 23'h000555;
	endfunction
	function automatic void ex(logic [22:0] x, logic [15:0] v);
		exq.push_back({x, v});
	endfunction
	function automatic void unl();
		ex(u1(), 16'h00AA);
		ex(byte_mode ? 23'h000555 : 23'h0002AA, 16'h0055);
	endfunction

	// ************
	// Command driver and comparison
	// ************
	task automatic run(cmd_t c, logic [15:0] v, logic er, mode_t m);
		int n;
		logic [38:0] g, e;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_addr <= a;
		cmd_data <= v;
		if (wq.size() != 0) begin
			word_valid <= 1'b1;
			{word_addr, word_data} <= wq[0];
		end
		n = 0;
		do @(posedge clock); while (cmd_ready !== 1'b1 && ++n < 100);
		cmd_valid <= 1'b0;
		n = 0;
		// Pairs go out one per take; ready drops the cycle after
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
			if (word_valid && word_ready === 1'b1) begin
				void'(wq.pop_front());
				if (wq.size() != 0) {word_addr, word_data} <= wq[0];
				else word_valid <= 1'b0;
			end
		end
		// Error pulse is gone by the next negedge: take it here
		er_g = rsp_error;
		@(negedge clock);
		`CHK(er_g, er)
		`CHK(mode, m)
		`CHK(i_flash_dev_model.log.size(), exq.size())
		while (exq.size() != 0 && i_flash_dev_model.log.size() != 0) begin
			g = i_flash_dev_model.log.pop_front();
			e = exq.pop_front();
			`CHK(g, e)
		end
		exq.delete();
		i_flash_dev_model.log.delete();
	endtask
	task automatic rd(cmd_t c, logic [15:0] e, mode_t m);
		run(c, 16'h0000, 1'b0, m);
		`CHK(rsp_data, e)
		`CHK(rsp_protected, e[7:0] == 8'h00)
	endtask
	task automatic ent(cmd_t c, logic [15:0] k, mode_t m);
		unl();
		ex(u1(), k);
		run(c, 16'h0000, 1'b0, m);
	endtask
	task automatic xit();
		ex(a, 16'h0090);
		ex(a, 16'h0000);
		run(CMD_SET_EXIT, 16'h0000, 1'b0, MD_ARRAY);
	endtask
	function automatic void pr();
		ex(a, 16'h00A0);
		ex(a, 16'h0000);
	endfunction
	task automatic tally_and_finish();
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ************
	// Clock, hang guard, scenarios
	// ************
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		{resetn, byte_mode, cmd_valid, word_valid} = 4'h0;
		{cmd_addr, word_addr, cmd_data, word_data, cmd_count} = '0;
		cmd_code = CMD_ARRAY_READ;
		a = 23'h0;
		void'($urandom(32'hC1987A09));
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		`CHK(cmd_ready, 1'b1)
		`CHK(mode, MD_ARRAY)
		for (int b = 0; b < 2; b++) begin
			@(posedge clock) byte_mode <= b[0];
			@(posedge clock);
			a = 23'($urandom) | 23'h400000;
			d = 16'($urandom);
			unl(); ex(u1(), 16'h00A0); ex(a, d);
			run(CMD_PROGRAM, d, 1'b0, MD_ARRAY);
			unl(); ex(u1(), 16'h0080); unl(); ex(u1(), 16'h0010);
			run(CMD_CHIP_ERASE, d, 1'b0, MD_ARRAY);
			unl(); ex(u1(), 16'h0080); unl(); ex(a, 16'h0030);
			run(CMD_SECT_ERASE, d, 1'b0, MD_ARRAY);
			cmd_count <= 8'h02;
			unl(); ex(a, 16'h0025); ex(a, 16'h0002);
			for (int i = 0; i < 3; i++) begin
				wq.push_back({a + 23'(i), 16'($urandom)});
				exq.push_back(wq[i]);
			end
			run(CMD_BUF_LOAD, d, 1'b0, MD_BUF);
			run(CMD_PROGRAM, d, 1'b1, MD_BUF);
			ex(a, 16'h0029);
			run(CMD_BUF_CONFIRM, d, 1'b0, MD_ARRAY);
			run(CMD_BUF_CONFIRM, d, 1'b1, MD_ARRAY);
			unl(); ex(u1(), 16'h00F0);
			run(CMD_BUF_ABORT, d, 1'b0, MD_ARRAY);
			ex(byte_mode ? 23'h0000AA : 23'h000055, 16'h0098);
			run(CMD_QUERY, d, 1'b0, MD_QUERY);
			run(CMD_PROGRAM, d, 1'b1, MD_QUERY);
			ex(a, 16'h00F0);
			run(CMD_RESET, d, 1'b0, MD_ARRAY);
			ex(a, 16'h00B0);
			run(CMD_SUSPEND, d, 1'b0, MD_SUSP);
			ex(a, 16'h0030);
			run(CMD_RESUME, d, 1'b0, MD_ARRAY);
			unl(); ex(a, 16'h00B9);
			run(CMD_DPD_ENTER, d, 1'b0, MD_DPD);
			run(CMD_PROGRAM, d, 1'b1, MD_DPD);
			ex(a, 16'h00AB);
			run(CMD_DPD_EXIT, d, 1'b0, MD_ARRAY);
			ent(CMD_LREG_ENTER, 16'h0040, MD_LREG);
			ex(a, 16'h00A0); ex(a, d);
			run(CMD_LREG_PROG, d, 1'b0, MD_LREG);
			rd(CMD_LREG_READ, d, MD_LREG);
			xit();
			ent(CMD_PPB_ENTER, 16'h00C0, MD_PPB);
			rd(CMD_PPB_READ, 16'h0001, MD_PPB);
			pr();
			run(CMD_PPB_PROG, d, 1'b0, MD_PPB);
			rd(CMD_PPB_READ, 16'h0000, MD_PPB);
			ex(a, 16'h0080); ex(23'h0, 16'h0030);
			run(CMD_PPB_ERASE, d, 1'b0, MD_PPB);
			rd(CMD_PPB_READ, 16'h0001, MD_PPB);
			xit();
			run(CMD_PPB_PROG, d, 1'b1, MD_ARRAY);
		end
		ent(CMD_FRZ_ENTER, 16'h0050, MD_FRZ);
		rd(CMD_FRZ_READ, 16'h0001, MD_FRZ);
		pr();
		run(CMD_FRZ_SET, d, 1'b0, MD_FRZ);
		rd(CMD_FRZ_READ, 16'h0000, MD_FRZ);
		xit();
		ent(CMD_PPB_ENTER, 16'h00C0, MD_PPB);
		pr();
		run(CMD_PPB_PROG, d, 1'b0, MD_PPB);
		rd(CMD_PPB_READ, 16'h0001, MD_PPB);
		xit();
		@(posedge clock);
		resetn <= 1'b0;
		byte_mode <= 1'b0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		ent(CMD_FRZ_ENTER, 16'h0050, MD_FRZ);
		rd(CMD_FRZ_READ, 16'h0001, MD_FRZ);
		xit();
		tally_and_finish();
	end
endmodule
